// ### inc/tmr_pkg.sv
// shared constants for the timer with output compare
package tmr_pkg;
  // register indices on the plain register port
  localparam logic [3:0] TMR_OFS_CONTROL = 4'h0;
  localparam logic [3:0] TMR_OFS_PERIOD_LO = 4'h1;
  localparam logic [3:0] TMR_OFS_PERIOD_HI = 4'h2;
  localparam logic [3:0] TMR_OFS_COUNT_LO = 4'h3;
  localparam logic [3:0] TMR_OFS_COUNT_HI = 4'h4;
  localparam logic [3:0] TMR_OFS_CMP_CONTROL = 4'h5;
  localparam logic [3:0] TMR_OFS_CMP_PRIMARY = 4'h6;
  localparam logic [3:0] TMR_OFS_CMP_SECONDARY = 4'h7;
  localparam logic [3:0] TMR_OFS_SECOND_RUN = 4'h8;
  // timer_control field positions
  localparam int TMR_BIT_COUNT_RUN = 15;
  localparam int TMR_BIT_IDLE_HALT = 13;
  localparam int TMR_BIT_GATE_ACC = 6;
  localparam int TMR_BIT_DIV_HI = 5;
  localparam int TMR_BIT_DIV_LO = 4;
  localparam int TMR_BIT_PAIR_WIDE = 3;
  localparam int TMR_BIT_CLK_SRC = 1;
  // compare_control_one field positions
  localparam int TMR_BIT_MODE_HI = 2;
  localparam int TMR_BIT_MODE_LO = 0;
  localparam int TMR_BIT_PIN_LEVEL = 4;
  // values after reset
  localparam logic [15:0] TMR_RST_CONTROL = 16'h0000;
  localparam logic [15:0] TMR_RST_PERIOD = 16'hFFFF;
  localparam logic [15:0] TMR_RST_VALUE = 16'h0000;
  // prescaler terminal counts for divide by 1, 8, 64, 256
  localparam logic [7:0] TMR_PRESC_TC_1 = 8'h00;
  localparam logic [7:0] TMR_PRESC_TC_8 = 8'h07;
  localparam logic [7:0] TMR_PRESC_TC_64 = 8'h3F;
  localparam logic [7:0] TMR_PRESC_TC_256 = 8'hFF;
  // compare mode codes
  localparam logic [2:0] TMR_CM_OFF = 3'h0;
  localparam logic [2:0] TMR_CM_ONE_HIGH = 3'h1;
  localparam logic [2:0] TMR_CM_ONE_LOW = 3'h2;
  localparam logic [2:0] TMR_CM_TOGGLE = 3'h3;
  localparam logic [2:0] TMR_CM_DUAL_SHOT = 3'h4;
  localparam logic [2:0] TMR_CM_DUAL_CONT = 3'h5;
  localparam logic [2:0] TMR_CM_PWM_EDGE = 3'h6;
  localparam logic [2:0] TMR_CM_PWM_CENTER = 3'h7;
  // compare sequence states
  typedef enum logic [1:0] {TMR_CS_IDLE, TMR_CS_WAIT_PRI, TMR_CS_WAIT_SEC, TMR_CS_DONE}
    tmr_cmp_state_type;
endpackage

// ### inc/tmr_chan_if.sv
`timescale 1ns/10ps
`default_nettype none
// carries the count and compare configuration to the compare channel
interface tmr_chan_if;
  logic [15:0] count_val;
  logic count_upd;
  logic [2:0] mode;
  logic mode_wr;
  logic [15:0] primary;
  logic [15:0] secondary;
  // count side
  modport cnt_src (output count_val, output count_upd);
  // configuration side
  modport cfg_src (output mode, output mode_wr, output primary, output secondary);
  // compare channel
  modport sink (input count_val, input count_upd, input mode, input mode_wr,
    input primary, input secondary);
endinterface
`default_nettype wire

// ### hw/tmr_counter.sv
`timescale 1ns/10ps
`default_nettype none
// pair of 16-bit counters, optionally joined into one 32-bit counter
module tmr_counter (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic tick,
  input wire logic pair_wide,
  input wire logic run_lo,
  input wire logic run_hi,
  input wire logic [15:0] period_lo,
  input wire logic [15:0] period_hi,
  // software load
  input wire logic load_lo,
  input wire logic load_hi,
  input wire logic [15:0] load_data,
  // count out
  output logic [15:0] count_hi,
  tmr_chan_if.cnt_src chan
);
  import tmr_pkg::*;

  logic [15:0] lo_reg;
  logic [15:0] lo_next;
  logic [15:0] hi_reg;
  logic [15:0] hi_next;
  logic upd_reg;
  logic [31:0] wide_val;
  logic [31:0] wide_inc;
  logic wide_wrap;
  logic step_lo;
  logic step_hi;

  // next count: wrap to zero after the period value
  assign wide_val = {hi_reg, lo_reg};
  assign wide_wrap = (wide_val == {period_hi, period_lo});
  assign wide_inc = wide_wrap ? 32'h0000_0000 : wide_val + 32'h0000_0001;  // [R16] [R6]
  assign step_lo = tick && run_lo;  // [R1]
  assign step_hi = tick && (pair_wide ? run_lo : run_hi);
  assign lo_next = load_lo ? load_data :
    (pair_wide ? wide_inc[15:0] : ((lo_reg == period_lo) ? 16'h0000 : lo_reg + 16'h0001));
  assign hi_next = load_hi ? load_data :
    (pair_wide ? wide_inc[31:16] : ((hi_reg == period_hi) ? 16'h0000 : hi_reg + 16'h0001));

  // count registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lo_reg <= TMR_RST_VALUE;
      hi_reg <= TMR_RST_VALUE;
      upd_reg <= 1'b0;
    end
    else
    begin
      if (load_lo || step_lo)
        lo_reg <= lo_next;
      if (load_hi || step_hi)
        hi_reg <= hi_next;
      upd_reg <= step_lo && !load_lo;  // marks a fresh count value
    end
  end

  assign count_hi = hi_reg;
  assign chan.count_val = lo_reg;
  assign chan.count_upd = upd_reg;
endmodule // tmr_counter
`default_nettype wire

// ### hw/tmr_compare.sv
`timescale 1ns/10ps
`default_nettype none
// output compare channel driving the compare pin
module tmr_compare (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // count and configuration
  tmr_chan_if.sink chan,
  // pin
  output logic pin_level,
  output logic pin_en
);
  import tmr_pkg::*;

  tmr_cmp_state_type state_reg;
  tmr_cmp_state_type state_next;
  logic out_reg;
  logic out_next;
  logic match_pri;
  logic match_sec;
  logic pwm_edge;
  logic pwm_center;

  // matches only on a freshly counted value
  assign match_pri = chan.count_upd && (chan.count_val == chan.primary);  // [R17]
  assign match_sec = chan.count_upd && (chan.count_val == chan.secondary);  // [R17]
  assign pwm_edge = (chan.count_val < chan.primary);
  assign pwm_center = (chan.count_val >= chan.primary) && (chan.count_val < chan.secondary);

  // mode sequencing
  always_comb
  begin
    state_next = state_reg;
    out_next = out_reg;
    if (chan.mode_wr)
    begin
      out_next = (chan.mode == TMR_CM_ONE_LOW);  // [R13] [R14] [R10] [R11]
      state_next = (chan.mode == TMR_CM_OFF) ? TMR_CS_IDLE : TMR_CS_WAIT_PRI;
    end
    else
    begin
      case (chan.mode)
        TMR_CM_OFF:
        begin
          out_next = 1'b0;  // [R15]
          state_next = TMR_CS_IDLE;
        end
        TMR_CM_ONE_HIGH:
          if (state_reg == TMR_CS_WAIT_PRI && match_pri)
          begin
            out_next = 1'b1;  // [R14]
            state_next = TMR_CS_DONE;
          end
        TMR_CM_ONE_LOW:
          if (state_reg == TMR_CS_WAIT_PRI && match_pri)
          begin
            out_next = 1'b0;  // [R13]
            state_next = TMR_CS_DONE;
          end
        TMR_CM_TOGGLE:
          if (match_pri)
            out_next = !out_reg;  // [R12]
        TMR_CM_DUAL_SHOT, TMR_CM_DUAL_CONT:
          if (state_reg == TMR_CS_WAIT_PRI && match_pri)
          begin
            out_next = 1'b1;  // [R10] [R11]
            state_next = TMR_CS_WAIT_SEC;
          end
          else if (state_reg == TMR_CS_WAIT_SEC && match_sec)
          begin
            out_next = 1'b0;
            state_next = (chan.mode == TMR_CM_DUAL_CONT) ? TMR_CS_WAIT_PRI  // [R10]
              : TMR_CS_DONE;  // [R11]
          end
        TMR_CM_PWM_EDGE:
          if (chan.count_upd)
            out_next = pwm_edge;  // [R9]
        TMR_CM_PWM_CENTER:
          if (chan.count_upd)
            out_next = pwm_center;  // [R8]
        default:
          out_next = 1'b0;
      endcase
    end
  end

  // state and pin registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= TMR_CS_IDLE;
      out_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      out_reg <= out_next;
    end
  end

  assign pin_level = out_reg;
  assign pin_en = (chan.mode != TMR_CM_OFF);  // [R15]
endmodule // tmr_compare
`default_nettype wire

// ### hw/tmr_top.sv
// Summary of operation
// R1 - With pair-wide mode off, the run bit starts and stops the 16-bit timer.
// R2 - With idle-halt set the timer halts while the device is idle, otherwise it keeps running.
// R3 - On the internal clock with gate accumulation on, the timer counts only while gate is high.
// R4 - On the external clock the gate-accumulation setting has no effect.
// R5 - The divider select divides the timer input clock by 1, 8, 64 or 256 for codes 0 to 3.
// R6 - Pair-wide mode joins the two timers into one 32-bit counter, else they run apart.
// R7 - Any write to the timer control register while running clears the prescale counter.
// R8 - Compare mode 111 gives a center-aligned PWM waveform on the compare pin.
// R9 - Compare mode 110 gives an edge-aligned PWM waveform on the compare pin.
// R10 - Mode 101 starts low and toggles on alternating primary and secondary matches forever.
// R11 - Mode 100 starts low, toggles on the primary then secondary match, one pulse only.
// R12 - Mode 011 toggles the pin on every compare match; the code toggles only on primary matches and ignores secondary matches.
// R13 - Mode 010 starts the pin high and drives it low on the first match.
// R14 - Mode 001 starts the pin low and drives it high on the first match.
// R15 - Mode 000 disables the compare channel.
// R16 - The timer steps once per prescaled tick and returns to zero after its period value.
// R17 - A match is flagged in the cycle the count equals the compare value under test.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module tmr_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // system state
  input wire logic device_idle,
  // pins
  input wire logic external_count_pin,
  input wire logic gate_pin,
  output logic compare_output_pin,
  output logic compare_output_en
);
  import tmr_pkg::*;

  // prescaler terminal count for a divider select code
  function automatic logic [7:0] presc_limit(input logic [1:0] sel);
    case (sel)
      2'h0: presc_limit = TMR_PRESC_TC_1;
      2'h1: presc_limit = TMR_PRESC_TC_8;
      2'h2: presc_limit = TMR_PRESC_TC_64;
      default: presc_limit = TMR_PRESC_TC_256;
    endcase
  endfunction

  // software registers
  logic [15:0] control_reg;
  logic [15:0] period_lo_reg;
  logic [15:0] period_hi_reg;
  logic [2:0] mode_reg;
  logic [15:0] primary_reg;
  logic [15:0] secondary_reg;
  logic second_run_reg;
  logic mode_wr_reg;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  // pin synchronisers
  logic [1:0] ext_sync_reg;
  logic ext_prev_reg;
  logic [1:0] gate_sync_reg;
  // prescaler
  logic [7:0] presc_reg;
  logic [7:0] presc_next;
  // decoded fields
  logic count_run;
  logic idle_halt;
  logic gate_accumulate;
  logic [1:0] input_divider_select;
  logic pair_wide_mode;
  logic clock_source_select;
  // decode and timing wires
  logic wr_control;
  logic wr_period_lo;
  logic wr_period_hi;
  logic wr_count_lo;
  logic wr_count_hi;
  logic wr_cmp_control;
  logic wr_primary;
  logic wr_secondary;
  logic wr_second_run;
  logic ext_rise;
  logic gate_level;
  logic src_tick;
  logic halted;
  logic any_run;
  logic presc_en;
  logic presc_tc;
  logic presc_clear;
  logic count_tick;
  logic [15:0] count_hi;
  logic pin_level;
  logic pin_en;

  tmr_chan_if chan ();

  // control field decode
  assign count_run = control_reg[TMR_BIT_COUNT_RUN];
  assign idle_halt = control_reg[TMR_BIT_IDLE_HALT];
  assign gate_accumulate = control_reg[TMR_BIT_GATE_ACC];
  assign input_divider_select = control_reg[TMR_BIT_DIV_HI:TMR_BIT_DIV_LO];
  assign pair_wide_mode = control_reg[TMR_BIT_PAIR_WIDE];
  assign clock_source_select = control_reg[TMR_BIT_CLK_SRC];

  // write strobe decode
  assign wr_control = reg_wr && (reg_addr == TMR_OFS_CONTROL);
  assign wr_period_lo = reg_wr && (reg_addr == TMR_OFS_PERIOD_LO);
  assign wr_period_hi = reg_wr && (reg_addr == TMR_OFS_PERIOD_HI);
  assign wr_count_lo = reg_wr && (reg_addr == TMR_OFS_COUNT_LO);
  assign wr_count_hi = reg_wr && (reg_addr == TMR_OFS_COUNT_HI);
  assign wr_cmp_control = reg_wr && (reg_addr == TMR_OFS_CMP_CONTROL);
  assign wr_primary = reg_wr && (reg_addr == TMR_OFS_CMP_PRIMARY);
  assign wr_secondary = reg_wr && (reg_addr == TMR_OFS_CMP_SECONDARY);
  assign wr_second_run = reg_wr && (reg_addr == TMR_OFS_SECOND_RUN);

  // software register storage, writable bits only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      control_reg <= TMR_RST_CONTROL;
      period_lo_reg <= TMR_RST_PERIOD;
      period_hi_reg <= TMR_RST_PERIOD;
      mode_reg <= TMR_CM_OFF;
      primary_reg <= TMR_RST_VALUE;
      secondary_reg <= TMR_RST_VALUE;
      second_run_reg <= 1'b0;
      mode_wr_reg <= 1'b0;
    end
    else
    begin
      if (wr_control)
        control_reg <= reg_wdata & 16'hA07A;  // unimplemented bits stay zero
      if (wr_period_lo)
        period_lo_reg <= reg_wdata;
      if (wr_period_hi)
        period_hi_reg <= reg_wdata;
      if (wr_cmp_control)
        mode_reg <= reg_wdata[TMR_BIT_MODE_HI:TMR_BIT_MODE_LO];
      if (wr_primary)
        primary_reg <= reg_wdata;
      if (wr_secondary)
        secondary_reg <= reg_wdata;
      if (wr_second_run)
        second_run_reg <= reg_wdata[0];
      mode_wr_reg <= wr_cmp_control;  // pin set-up waits until the new mode is stored
    end
  end

  // two-flop synchronisers for the pins, plus edge history
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ext_sync_reg <= 2'h0;
      ext_prev_reg <= 1'b0;
      gate_sync_reg <= 2'h0;
    end
    else
    begin
      ext_sync_reg <= {ext_sync_reg[0], external_count_pin};
      ext_prev_reg <= ext_sync_reg[1];
      gate_sync_reg <= {gate_sync_reg[0], gate_pin};
    end
  end

  // input clock selection and gating
  assign ext_rise = ext_sync_reg[1] && !ext_prev_reg;
  assign gate_level = gate_sync_reg[1];
  assign src_tick = clock_source_select ? ext_rise  // [R4]
    : (!gate_accumulate || gate_level);  // [R3]
  assign halted = idle_halt && device_idle;  // [R2]
  assign any_run = count_run || (!pair_wide_mode && second_run_reg);  // [R1] [R6]
  assign presc_en = any_run && !halted && src_tick;

  // prescaler: divide the input ticks by the selected ratio
  assign presc_tc = (presc_reg == presc_limit(input_divider_select));  // [R5]
  assign presc_clear = wr_control && count_run;  // [R7]
  assign count_tick = presc_en && presc_tc && !presc_clear;
  assign presc_next = presc_clear ? 8'h00 :
    (presc_en ? (presc_tc ? 8'h00 : presc_reg + 8'h01) : presc_reg);

  // prescale counter
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      presc_reg <= 8'h00;
    else
      presc_reg <= presc_next;  // [R5] [R7]
  end

  // the counter halts with the rest of the timer in idle when idle-halt is set
  tmr_counter u_counter (
    .clk(clk),
    .rst(rst),
    .tick(count_tick),  // [R16]
    .pair_wide(pair_wide_mode),  // [R6]
    .run_lo(count_run),  // [R1]
    .run_hi(second_run_reg),
    .period_lo(period_lo_reg),
    .period_hi(period_hi_reg),
    .load_lo(wr_count_lo),
    .load_hi(wr_count_hi),
    .load_data(reg_wdata),
    .count_hi(count_hi),
    .chan(chan.cnt_src)
  );

  // compare configuration onto the channel
  assign chan.mode = mode_reg;
  assign chan.mode_wr = mode_wr_reg;  // [R13] [R14]
  assign chan.primary = primary_reg;
  assign chan.secondary = secondary_reg;

  tmr_compare u_compare (
    .clk(clk),
    .rst(rst),
    .chan(chan.sink),
    .pin_level(pin_level),
    .pin_en(pin_en)
  );

  assign compare_output_pin = pin_level;
  assign compare_output_en = pin_en;

  // read data selection
  always_comb
  begin
    rdata_next = 16'h0000;
    if (reg_rd)
    begin
      case (reg_addr)
        TMR_OFS_CONTROL: rdata_next = control_reg;
        TMR_OFS_PERIOD_LO: rdata_next = period_lo_reg;
        TMR_OFS_PERIOD_HI: rdata_next = period_hi_reg;
        TMR_OFS_COUNT_LO: rdata_next = chan.count_val;
        TMR_OFS_COUNT_HI: rdata_next = count_hi;
        TMR_OFS_CMP_CONTROL:
        begin
          rdata_next[TMR_BIT_MODE_HI:TMR_BIT_MODE_LO] = mode_reg;
          rdata_next[TMR_BIT_PIN_LEVEL] = pin_level;  // live pin state
        end
        TMR_OFS_CMP_PRIMARY: rdata_next = primary_reg;
        TMR_OFS_CMP_SECONDARY: rdata_next = secondary_reg;
        TMR_OFS_SECOND_RUN: rdata_next = {15'h0000, second_run_reg};
        default: rdata_next = 16'h0000;  // unmapped reads as zero
      endcase
    end
  end

  // read data register, valid the cycle after the strobe only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_reg <= 16'h0000;
    else
      rdata_reg <= rdata_next;
  end

  assign reg_rdata = rdata_reg;
endmodule // tmr_top
`default_nettype wire

// ### testbench/tmr_chk.sv
`timescale 1ns/10ps
`default_nettype none
// watches register port and compare pin of the timer top
module tmr_chk
  import tmr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // pins
  input wire logic compare_output_pin,
  input wire logic compare_output_en
);
  // decoded register accesses
  wire cmp_wr = reg_wr && reg_addr == TMR_OFS_CMP_CONTROL;
  wire ctl_wr = reg_wr && reg_addr == TMR_OFS_CONTROL;
  wire ctl_rd = reg_rd && reg_addr == TMR_OFS_CONTROL;
  wire [2:0] new_mode = reg_wdata[2:0];

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // enable follows the compare mode register
  a_mode_off_en: assert property (
    cmp_wr && new_mode == TMR_CM_OFF |=> !compare_output_en)
    else $error("compare enable still high after mode off");
  a_mode_on_en: assert property (
    cmp_wr && new_mode != TMR_CM_OFF |=> compare_output_en)
    else $error("compare enable low after mode on");
  a_en_write_only: assert property (
    !$past(cmp_wr) |-> $stable(compare_output_en))
    else $error("compare enable moved without a mode write");
  a_off_pin_low: assert property (
    !compare_output_en && !$past(compare_output_en) |-> !compare_output_pin)
    else $error("compare pin high while channel disabled");
  // pin initialisation on a mode write
  a_init_pin_high: assert property (
    cmp_wr && new_mode == TMR_CM_ONE_LOW |=> ##1 compare_output_pin)
    else $error("pin not initialised high");
  a_init_pin_low: assert property (
    cmp_wr && new_mode == TMR_CM_ONE_HIGH |=> ##1 !compare_output_pin)
    else $error("pin not initialised low");
  a_init_dual_low: assert property (
    cmp_wr && new_mode[2:1] == 2'b10 |=> ##1 !compare_output_pin)
    else $error("dual mode pin not initialised low");
  // control fields read back through the write mask
  a_ctrl_readback: assert property (
    ctl_wr ##1 !reg_wr ##1 ctl_rd |=> reg_rdata == ($past(reg_wdata, 3) & 16'hA07A))
    else $error("control register read back wrong");

  // main scenarios reached
  c_center_pwm: cover property (cmp_wr && new_mode == TMR_CM_PWM_CENTER);
  c_pin_rise: cover property ($rose(compare_output_pin));
  c_ctrl_read: cover property (ctl_rd);
endmodule // tmr_chk
bind tmr_top tmr_chk u_tmr_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .compare_output_pin(compare_output_pin), .compare_output_en(compare_output_en));
`default_nettype wire

// ### testbench/test_timer_with_output_compare.sv
`timescale 1ns/10ps
`default_nettype none
// self-checking bench for the timer with output compare
module test_timer_with_output_compare;
  import tmr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic device_idle = 1'b0;
  logic external_count_pin = 1'b0;
  logic gate_pin = 1'b0;
  wire logic [15:0] reg_rdata;
  wire logic compare_output_pin;
  wire logic compare_output_en;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;

  // block under test
  tmr_top u_tmr_top (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .device_idle(device_idle),
    .external_count_pin(external_count_pin), .gate_pin(gate_pin),
    .compare_output_pin(compare_output_pin), .compare_output_en(compare_output_en));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_fail++;
      print_verdict;
    end
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle write strobe, released on the next edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // count advance between two reads gap+2 edges apart
  task automatic step_over(input int gap, input logic [15:0] exp);
    logic [15:0] a, b;
    rd(TMR_OFS_COUNT_LO, a);
    repeat (gap) @(posedge clk);
    rd(TMR_OFS_COUNT_LO, b);
    check("count advance", b - a, exp);
  endtask

  task automatic t_reset;
    logic [15:0] exp [0:9] = '{16'h0000, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] v;
    for (int i = 0; i < 10; i++)
    begin
      rd(4'(i), v);
      check("register after reset", v, exp[i]);
    end
    check("pin enable after reset", {15'h0000, compare_output_en}, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_ctrl;
    logic [15:0] v;
    wr(TMR_OFS_CONTROL, 16'hFFFF);
    rd(TMR_OFS_CONTROL, v);
    check("control readback", v, 16'hA07A);
    wr(TMR_OFS_CONTROL, 16'h0000);
    $display("test control done");
  endtask

  task automatic t_run_div;
    int sh [0:3] = '{0, 3, 6, 8};
    for (int c = 0; c < 4; c++)
    begin
      wr(TMR_OFS_CONTROL, 16'h8000 | 16'(c << 4));
      step_over(510, 16'(512 >> sh[c]));
    end
    wr(TMR_OFS_CONTROL, 16'h0000);
    step_over(10, 16'h0000);
    $display("test run and divider done");
  endtask

  task automatic t_idle_gate;
    logic [15:0] a, b;
    @(posedge clk) device_idle <= 1'b1;
    wr(TMR_OFS_CONTROL, 16'hA000);
    step_over(10, 16'h0000);
    wr(TMR_OFS_CONTROL, 16'h8000);
    step_over(10, 16'h000C);
    @(posedge clk) device_idle <= 1'b0;
    wr(TMR_OFS_CONTROL, 16'h8040);
    step_over(10, 16'h0000);
    @(posedge clk) gate_pin <= 1'b1;
    repeat (4) @(posedge clk);
    step_over(10, 16'h000C);
    @(posedge clk) gate_pin <= 1'b0;
    wr(TMR_OFS_CONTROL, 16'h8042);
    rd(TMR_OFS_COUNT_LO, a);
    repeat (5)
    begin
      @(posedge clk) external_count_pin <= 1'b1;
      repeat (3) @(posedge clk);
      external_count_pin <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (6) @(posedge clk);
    rd(TMR_OFS_COUNT_LO, b);
    check("external edges counted", b - a, 16'h0005);
    $display("test idle and gate done");
  endtask

  task automatic t_presc_clear;
    logic [15:0] v;
    wr(TMR_OFS_CONTROL, 16'h0000);
    wr(TMR_OFS_COUNT_LO, 16'h0000);
    wr(TMR_OFS_CONTROL, 16'h8030);
    repeat (200) @(posedge clk);
    wr(TMR_OFS_CONTROL, 16'h8030);
    repeat (100) @(posedge clk);
    rd(TMR_OFS_COUNT_LO, v);
    check("count after prescaler clear", v, 16'h0000);
    repeat (200) @(posedge clk);
    rd(TMR_OFS_COUNT_LO, v);
    check("count after full prescale", v, 16'h0001);
    $display("test prescaler clear done");
  endtask

  task automatic t_pair;
    logic [15:0] v;
    logic [15:0] ctl [0:1] = '{16'h8008, 16'h8000};
    logic [15:0] hi [0:1] = '{16'h0002, 16'h0001};
    for (int k = 0; k < 2; k++)
    begin
      wr(TMR_OFS_CONTROL, 16'h0000);
      wr(TMR_OFS_COUNT_LO, 16'hFFFE);
      wr(TMR_OFS_COUNT_HI, 16'h0001);
      wr(TMR_OFS_CONTROL, ctl[k]);
      repeat (4) @(posedge clk);
      wr(TMR_OFS_CONTROL, 16'h0000);
      rd(TMR_OFS_COUNT_HI, v);
      check("upper half after low wrap", v, hi[k]);
    end
    // second timer alone: six steps, no prescaler clear on its own run bit
    wr(TMR_OFS_SECOND_RUN, 16'h0001);
    repeat (4) @(posedge clk);
    wr(TMR_OFS_SECOND_RUN, 16'h0000);
    rd(TMR_OFS_COUNT_HI, v);
    check("second timer alone", v, 16'h0007);
    $display("test pair mode done");
  endtask

  task automatic t_compare;
    int er [0:7] = '{0, 1, 0, 2, 1, 4, 4, 4};
    int ef [0:7] = '{0, 0, 1, 2, 1, 4, 4, 4};
    int eh [0:7] = '{0, -1, -1, 20, 5, 20, 12, 20};
    int el [0:7] = '{0, 1, 0, -1, 0, -1, -1, -1};
    int r, f, h;
    logic prev;
    wr(TMR_OFS_PERIOD_LO, 16'h0009);
    wr(TMR_OFS_CMP_PRIMARY, 16'h0003);
    wr(TMR_OFS_CMP_SECONDARY, 16'h0008);
    for (int m = 0; m < 8; m++)
    begin
      wr(TMR_OFS_CONTROL, 16'h0000);
      wr(TMR_OFS_COUNT_LO, 16'h0000);
      wr(TMR_OFS_CMP_CONTROL, 16'(m));
      repeat (2) @(posedge clk);
      #1;
      check("pin enable", {15'h0000, compare_output_en}, 16'(m != 0));
      if (m < 6)
        check("initial pin", {15'h0000, compare_output_pin}, 16'(m == 2));
      wr(TMR_OFS_CONTROL, 16'h8000);
      if (m == 3 || m > 4)
        repeat (10) @(posedge clk);
      #1 prev = compare_output_pin;
      r = 0;
      f = 0;
      h = 0;
      repeat (40)
      begin
        @(posedge clk);
        #1;
        r += int'(compare_output_pin && !prev);
        f += int'(!compare_output_pin && prev);
        h += int'(compare_output_pin);
        prev = compare_output_pin;
      end
      check("pin rises", 16'(r), 16'(er[m]));
      check("pin falls", 16'(f), 16'(ef[m]));
      if (eh[m] >= 0)
        check("pin high cycles", 16'(h), 16'(eh[m]));
      if (el[m] >= 0)
        check("final pin", {15'h0000, prev}, 16'(el[m]));
    end
    $display("test compare modes done");
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_ctrl;
    t_run_div;
    t_idle_gate;
    t_presc_clear;
    t_pair;
    t_compare;
    print_verdict;
  end
endmodule // test_timer_with_output_compare
`default_nettype wire
